/* File: vosr_regs.sv */
module vosr_regs (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Command port
    input wire vosr_pkg::vosr_cmd_t hostCmd,
    output vosr_pkg::vosr_rsp_t hostRsp,
    // Per output settings in force
    output vosr_pkg::vosr_out_t outSet [2],
    // Status
    output logic invalidDataFault
);
    import vosr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] page_r;
    logic [7:0] writeProtect_r;
    logic [7:0] operation_r [2];
    logic [15:0] nominal_r [2];
    logic [15:0] offset_r [2];
    logic [15:0] upperClamp_r [2];
    logic [15:0] marginHigh_r [2];
    logic [15:0] marginLow_r [2];
    logic [15:0] slew_r [2];
    logic [15:0] loadLine_r [2];
    // Committed loop settings and registered target, one writer each
    logic [15:0] slewAct_r [2];
    logic [15:0] loadLineAct_r [2];
    logic [15:0] target_r [2];
    logic [15:0] target_nxt [2];
    logic [15:0] rdData;
    logic wrCmd;
    logic rdCmd;
    logic bankWrOk;
    logic wpValid;
    logic pageValid;
    logic rdPage;

    function automatic logic pageHit(input logic [7:0] pg, input int idx);
        pageHit = (pg == PAGE_BOTH) || (pg == (idx == 0 ? PAGE_OUT0 : PAGE_OUT1));
    endfunction

    function automatic logic protectAllows(input logic [7:0] wp, input logic [7:0] code);
        protectAllows = (wp == WP_OPEN) ||
            ((wp == WP_SETPOINT_ONLY) && (code == CMD_NOMINAL || code == CMD_OFFSET));
    endfunction

    assign wrCmd = hostCmd.valid && hostCmd.write;
    assign rdCmd = hostCmd.valid && !hostCmd.write;
    assign bankWrOk = wrCmd && protectAllows(writeProtect_r, hostCmd.code);
    assign wpValid = hostCmd.data[7:0] == WP_OPEN || hostCmd.data[7:0] == WP_SETPOINT_ONLY ||
        hostCmd.data[7:0] == WP_LOCKED;
    assign pageValid = hostCmd.data[7:0] == PAGE_OUT0 || hostCmd.data[7:0] == PAGE_OUT1 ||
        hostCmd.data[7:0] == PAGE_BOTH;
    // Reads with both pages selected answer from output 0
    assign rdPage = page_r == PAGE_OUT1;

    ////////////////////////////////////////////////////////////////////////
    // Global selection registers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            page_r <= RST_PAGE;
            writeProtect_r <= RST_WRITE_PROTECT;
        end else if (wrCmd) begin
            if (hostCmd.code == CMD_PAGE && pageValid) begin
                page_r <= hostCmd.data[7:0];
            end
            if (hostCmd.code == CMD_WRITE_PROTECT && wpValid) begin
                writeProtect_r <= hostCmd.data[7:0];
            end
        end
    end

    // Invalid data fault: a new fault wins over a clear in the same cycle
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            invalidDataFault <= 1'b0;
        end else if (wrCmd && ((hostCmd.code == CMD_WRITE_PROTECT && !wpValid) ||
                (hostCmd.code == CMD_PAGE && !pageValid))) begin
            invalidDataFault <= 1'b1;
        end else if (wrCmd && hostCmd.code == CMD_CLEAR_FAULTS) begin
            invalidDataFault <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Paged setting bank
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (int p = 0; p < 2; p++) begin
                operation_r[p] <= RST_OPERATION;
                nominal_r[p] <= RST_NOMINAL;
                offset_r[p] <= RST_OFFSET;
                upperClamp_r[p] <= RST_UPPER_CLAMP;
                marginHigh_r[p] <= RST_MARGIN_HIGH;
                marginLow_r[p] <= RST_MARGIN_LOW;
                slew_r[p] <= RST_SLEW;
                loadLine_r[p] <= RST_LOAD_LINE;
            end
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (wrCmd && pageHit(page_r, p) && hostCmd.code == CMD_OPERATION) begin
                    operation_r[p] <= hostCmd.data[7:0];
                end
                if (bankWrOk && pageHit(page_r, p)) begin
                    unique case (hostCmd.code)
                        CMD_NOMINAL: nominal_r[p] <= hostCmd.data;
                        CMD_OFFSET: offset_r[p] <= hostCmd.data;
                        CMD_UPPER_CLAMP: upperClamp_r[p] <= hostCmd.data;
                        CMD_MARGIN_HIGH: marginHigh_r[p] <= hostCmd.data;
                        CMD_MARGIN_LOW: marginLow_r[p] <= hostCmd.data;
                        CMD_SLEW: slew_r[p] <= hostCmd.data;
                        CMD_LOAD_LINE: loadLine_r[p] <= hostCmd.data;
                        default: ;
                    endcase
                end
            end
        end
    end

    // Slew and load line reach the loop only on commit
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (int p = 0; p < 2; p++) begin
                slewAct_r[p] <= RST_SLEW;
                loadLineAct_r[p] <= RST_LOAD_LINE;
            end
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (wrCmd && hostCmd.code == CMD_COMMIT && pageHit(page_r, p)) begin
                    slewAct_r[p] <= slew_r[p];
                    loadLineAct_r[p] <= loadLine_r[p];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Effective target: selected source plus trim, clamped at the top
    always_comb begin
        logic signed [16:0] sum;
        logic [15:0] src;
        sum = '0;
        src = '0;
        for (int p = 0; p < 2; p++) begin
            unique case (vosr_src_t'(operation_r[p][SRC_LSB +: 2]))
                SRC_MARGIN_LOW: src = marginLow_r[p];
                SRC_MARGIN_HIGH: src = marginHigh_r[p];
                default: src = nominal_r[p];
            endcase
            sum = signed'({src[15], src}) + signed'({offset_r[p][15], offset_r[p]});
            if (sum > signed'({upperClamp_r[p][15], upperClamp_r[p]})) begin
                target_nxt[p] = upperClamp_r[p];
            end else begin
                target_nxt[p] = sum[15:0];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (int p = 0; p < 2; p++) begin
                target_r[p] <= RST_NOMINAL;
            end
        end else begin
            for (int p = 0; p < 2; p++) begin
                // Target follows its sources one edge late
                target_r[p] <= target_nxt[p];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ports show the flops directly
    assign outSet[0] = '{target_r[0], slewAct_r[0], loadLineAct_r[0]};
    assign outSet[1] = '{target_r[1], slewAct_r[1], loadLineAct_r[1]};

    ////////////////////////////////////////////////////////////////////////
    // Read path
    always_comb begin
        unique case (hostCmd.code)
            CMD_PAGE: rdData = {8'h00, page_r};
            CMD_OPERATION: rdData = {8'h00, operation_r[rdPage]};
            CMD_WRITE_PROTECT: rdData = {8'h00, writeProtect_r};
            CMD_FORMAT_MODE: rdData = {8'h00, FORMAT_MODE_VAL};
            CMD_NOMINAL: rdData = nominal_r[rdPage];
            CMD_OFFSET: rdData = offset_r[rdPage];
            CMD_UPPER_CLAMP: rdData = upperClamp_r[rdPage];
            CMD_MARGIN_HIGH: rdData = marginHigh_r[rdPage];
            CMD_MARGIN_LOW: rdData = marginLow_r[rdPage];
            CMD_SLEW: rdData = slew_r[rdPage];
            CMD_LOAD_LINE: rdData = loadLine_r[rdPage];
            default: rdData = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            hostRsp <= '0;
        end else begin
            hostRsp.valid <= rdCmd;
            hostRsp.data <= rdCmd ? rdData : 16'h0000;
        end
    end

endmodule

/* File: vosr_pkg.sv */
package vosr_pkg;

    // Command codes
    localparam logic [7:0] CMD_PAGE = 8'h00;
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_WRITE_PROTECT = 8'h10;
    localparam logic [7:0] CMD_FORMAT_MODE = 8'h20;
    localparam logic [7:0] CMD_NOMINAL = 8'h21;
    localparam logic [7:0] CMD_OFFSET = 8'h22;
    localparam logic [7:0] CMD_UPPER_CLAMP = 8'h24;
    localparam logic [7:0] CMD_MARGIN_HIGH = 8'h25;
    localparam logic [7:0] CMD_MARGIN_LOW = 8'h26;
    localparam logic [7:0] CMD_SLEW = 8'h27;
    localparam logic [7:0] CMD_LOAD_LINE = 8'h28;
    localparam logic [7:0] CMD_COMMIT = 8'he7;

    // Values after reset
    localparam logic [7:0] RST_PAGE = 8'h00;
    localparam logic [7:0] RST_OPERATION = 8'h08;
    localparam logic [7:0] RST_WRITE_PROTECT = 8'h00;
    localparam logic [7:0] FORMAT_MODE_VAL = 8'h40;
    localparam logic [15:0] RST_NOMINAL = 16'h0384;
    localparam logic [15:0] RST_OFFSET = 16'h0000;
    localparam logic [15:0] RST_UPPER_CLAMP = 16'h08fc;
    localparam logic [15:0] RST_MARGIN_HIGH = 16'h0640;
    localparam logic [15:0] RST_MARGIN_LOW = 16'h00fa;
    localparam logic [15:0] RST_SLEW = 16'h0064;
    localparam logic [15:0] RST_LOAD_LINE = 16'h0000;

    // Page selections
    localparam logic [7:0] PAGE_OUT0 = 8'h00;
    localparam logic [7:0] PAGE_OUT1 = 8'h01;
    localparam logic [7:0] PAGE_BOTH = 8'hff;

    // Write protect settings
    localparam logic [7:0] WP_OPEN = 8'h00;
    localparam logic [7:0] WP_SETPOINT_ONLY = 8'h20;
    localparam logic [7:0] WP_LOCKED = 8'h40;

    // Source select field of the operation byte
    localparam int SRC_LSB = 4;
    typedef enum logic [1:0] {
        SRC_NOMINAL = 2'h0,
        SRC_MARGIN_LOW = 2'h1,
        SRC_MARGIN_HIGH = 2'h2,
        SRC_UNUSED = 2'h3
    } vosr_src_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] data;
    } vosr_cmd_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } vosr_rsp_t;

    typedef struct packed {
        logic [15:0] target;
        logic [15:0] slew;
        logic [15:0] loadLine;
    } vosr_out_t;

endpackage

/* File: vosr_regs_checker.sv */
module vosr_regs_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Watched ports
    input wire vosr_pkg::vosr_cmd_t hostCmd,
    input wire vosr_pkg::vosr_rsp_t hostRsp,
    input wire vosr_pkg::vosr_out_t outSet [2],
    input wire logic invalidDataFault
);
    timeunit 1ns;
    timeprecision 1ns;
    import vosr_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic rdNow;
    logic wrNow;
    assign rdNow = hostCmd.valid && !hostCmd.write;
    assign wrNow = hostCmd.valid && hostCmd.write;
    ////////////////////////////////////////
    rsp_after_read_a: assert property (rdNow |=> hostRsp.valid)
        else $error("read got no answer");
    rsp_only_read_a: assert property (hostRsp.valid |-> $past(rdNow))
        else $error("answer without read");
    rsp_idle_zero_a: assert property (!hostRsp.valid |-> hostRsp.data == 16'h0000)
        else $error("idle answer data not zero");
    mode_const_a: assert property (rdNow && hostCmd.code == CMD_FORMAT_MODE
        |=> hostRsp.data == 16'h0040) else $error("format mode read wrong");
    slew_commit_a: assert property ($changed(outSet[0].slew)
        |-> $past(wrNow && hostCmd.code == CMD_COMMIT)) else $error("slew moved alone");
    droop_commit_a: assert property ($changed(outSet[0].loadLine)
        |-> $past(wrNow && hostCmd.code == CMD_COMMIT)) else $error("droop moved alone");
    target_late_a: assert property ($changed(outSet[0].target) |-> $past(wrNow, 2))
        else $error("target moved without write");
    fault_cause_a: assert property ($rose(invalidDataFault) |-> $past(wrNow &&
        (hostCmd.code == CMD_PAGE || hostCmd.code == CMD_WRITE_PROTECT)))
        else $error("fault without bad write");
    fault_clear_a: assert property (wrNow && hostCmd.code == CMD_CLEAR_FAULTS
        |=> !invalidDataFault) else $error("fault not cleared");
endmodule

/* File: vosr_host.sv */
module vosr_host (
    // Clock
    input wire logic sys_clk,
    // Command port
    output vosr_pkg::vosr_cmd_t hostCmd
);
    timeunit 1ns;
    timeprecision 1ns;
    import vosr_pkg::*;
    initial hostCmd = '0;
    // Idle fields inverted so a stale command is never mistaken for a live one
    task automatic issue(input logic wr, input logic [7:0] code, input logic [15:0] data);
        @(negedge sys_clk);
        hostCmd <= '{1'b1, wr, code, data};
        @(negedge sys_clk);
        hostCmd <= '{1'b0, ~wr, ~code, ~data};
    endtask
endmodule

/* File: vosr_regs_tb.sv */
module vosr_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import vosr_pkg::*;
    logic sys_clk;
    logic reset = 1'b1;
    vosr_cmd_t hostCmd;
    vosr_rsp_t hostRsp;
    vosr_out_t outSet [2];
    logic invalidDataFault;
    logic [15:0] expQ [$];
    logic [31:0] seed = 32'ha24a;
    logic [15:0] v;
    logic [15:0] s;
    int fails = 0;
    int samples_checked = 0;
    logic [7:0] codes [8] = '{CMD_FORMAT_MODE, CMD_NOMINAL, CMD_OFFSET, CMD_UPPER_CLAMP,
        CMD_MARGIN_HIGH, CMD_MARGIN_LOW, CMD_SLEW, CMD_LOAD_LINE};
    logic [15:0] rstv [8] = '{{8'h00, FORMAT_MODE_VAL}, RST_NOMINAL, RST_OFFSET,
        RST_UPPER_CLAMP, RST_MARGIN_HIGH, RST_MARGIN_LOW, RST_SLEW, RST_LOAD_LINE};
    vosr_host host (.sys_clk(sys_clk), .hostCmd(hostCmd));
    vosr_regs dut (.sys_clk(sys_clk), .reset(reset), .hostCmd(hostCmd), .hostRsp(hostRsp),
        .outSet(outSet), .invalidDataFault(invalidDataFault));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        host.issue(1'b1, code, data);
    endtask
    task automatic rd(input logic [7:0] code, input logic [15:0] exp);
        expQ.push_back(exp);
        host.issue(1'b0, code, 16'h0000);
    endtask
    task automatic tgt(input int p, input logic [15:0] exp);
        @(negedge sys_clk);
        check("target", exp, outSet[p].target);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Answers are matched in order against the notes left by the reads
    always @(negedge sys_clk) begin
        if (hostRsp.valid === 1'b1) begin
            if (expQ.size() == 0) begin
                fails++;
                $display("mismatch rsp exp none got %h", hostRsp.data);
            end else begin
                check("rsp", expQ.pop_front(), hostRsp.data);
            end
        end
    end
    ////////////////////////////////////////
    initial begin
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        reset <= 1'b0;
        tgt(0, RST_NOMINAL);
        check("slew", RST_SLEW, outSet[1].slew);
        for (int i = 0; i < 8; i++) rd(codes[i], rstv[i]);
        wr(CMD_FORMAT_MODE, 16'h00aa);
        rd(CMD_FORMAT_MODE, 16'h0040);
        $display("test reset values done");
        s = rnd();
        v = 16'h0100 + {6'h00, s[9:0]};
        wr(CMD_PAGE, {8'h00, PAGE_OUT1});
        wr(CMD_NOMINAL, v);
        rd(CMD_NOMINAL, v);
        wr(CMD_PAGE, {8'h00, PAGE_OUT0});
        rd(CMD_NOMINAL, RST_NOMINAL);
        wr(CMD_PAGE, {8'h00, PAGE_BOTH});
        wr(CMD_OFFSET, 16'hfff6);
        tgt(0, RST_NOMINAL - 16'h000a);
        tgt(1, v - 16'h000a);
        wr(CMD_PAGE, {8'h00, PAGE_OUT0});
        $display("test paging done");
        wr(CMD_OPERATION, 16'h0018);
        tgt(0, RST_MARGIN_LOW - 16'h000a);
        wr(CMD_OPERATION, 16'h0028);
        tgt(0, RST_MARGIN_HIGH - 16'h000a);
        wr(CMD_UPPER_CLAMP, 16'h0500);
        tgt(0, 16'h0500);
        wr(CMD_OPERATION, 16'h0008);
        tgt(0, RST_NOMINAL - 16'h000a);
        $display("test source select done");
        s = rnd();
        s = {7'h00, s[8:0]} + 16'h0001;
        wr(CMD_SLEW, s);
        wr(CMD_LOAD_LINE, 16'h0050);
        rd(CMD_SLEW, s);
        check("slew", RST_SLEW, outSet[0].slew);
        wr(CMD_COMMIT, 16'h0000);
        tgt(0, RST_NOMINAL - 16'h000a);
        check("slew", s, outSet[0].slew);
        check("loadLine", 16'h0050, outSet[0].loadLine);
        check("slew", RST_SLEW, outSet[1].slew);
        check("loadLine", RST_LOAD_LINE, outSet[1].loadLine);
        $display("test commit done");
        wr(CMD_WRITE_PROTECT, {8'h00, WP_LOCKED});
        wr(CMD_NOMINAL, 16'h0200);
        rd(CMD_NOMINAL, RST_NOMINAL);
        wr(CMD_WRITE_PROTECT, {8'h00, WP_SETPOINT_ONLY});
        wr(CMD_NOMINAL, 16'h0200);
        wr(CMD_MARGIN_HIGH, 16'h0111);
        rd(CMD_NOMINAL, 16'h0200);
        rd(CMD_MARGIN_HIGH, RST_MARGIN_HIGH);
        wr(CMD_WRITE_PROTECT, 16'h0033);
        rd(CMD_WRITE_PROTECT, {8'h00, WP_SETPOINT_ONLY});
        check("fault", 16'h0001, {15'h0000, invalidDataFault});
        wr(CMD_CLEAR_FAULTS, 16'h0000);
        check("fault", 16'h0000, {15'h0000, invalidDataFault});
        wr(CMD_PAGE, 16'h0005);
        rd(CMD_PAGE, {8'h00, PAGE_OUT0});
        check("fault", 16'h0001, {15'h0000, invalidDataFault});
        wr(CMD_CLEAR_FAULTS, 16'h0000);
        check("fault", 16'h0000, {15'h0000, invalidDataFault});
        wr(CMD_OPERATION, 16'h0038);
        tgt(0, 16'h0200 - 16'h000a);
        rd(CMD_OPERATION, 16'h0038);
        $display("test protect done");
        for (int i = 0; i < 20 && expQ.size() > 0; i++) @(negedge sys_clk);
        if (expQ.size() > 0) begin
            fails++;
            $display("mismatch rsp exp %0d more got none", expQ.size());
        end
        print_verdict();
    end
endmodule
bind vosr_regs vosr_regs_checker chk (.sys_clk(sys_clk), .reset(reset), .hostCmd(hostCmd),
    .hostRsp(hostRsp), .outSet(outSet), .invalidDataFault(invalidDataFault));
